/* hw/rxic_top.sv */
/*
 * Receive interface control for a two-channel line interface: decodes the
 * sliced line pulses, launches rails and recovered clock, and maps the shared
 * control pins between hardware mode and host mode.
 * Assumes every pin input is asynchronous to the 200 MHz ref_clk and that the
 * host register file and serial port logic run on ref_clk.
 */
`timescale 1ns/1ps
module rxic_top import rxic_pkg::*; #(
	parameter int NCH = RXIC_NCH
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Mode select pin
	input wire logic host_mode_pin,
	// Shared control pins
	input wire logic [NCH-1:0] rx_equalizer_enable_pin,
	input wire logic receiver_turn_on,
	input wire logic rx_clock_invert_pin,
	input wire logic rx_monitor_mode_pin_in,
	output logic rx_monitor_mode_pin_out,
	output logic rx_monitor_mode_pin_oe_n,
	// Line side, from the slicers and clock recovery
	input wire logic [NCH-1:0] line_clock,
	input wire logic [NCH-1:0] line_pos,
	input wire logic [NCH-1:0] line_neg,
	input wire logic [NCH-1:0] los_detect,
	// Host register bits
	input wire logic [NCH-1:0] host_equalizer_bit,
	input wire logic [NCH-1:0] host_receiver_enable,
	input wire logic [NCH-1:0] host_monitor_bit,
	input wire logic [NCH-1:0] rx_clock_invert_bit,
	input wire logic [NCH-1:0] single_rail,
	input wire logic [NCH-1:0] decoder_enable,
	input wire logic [NCH-1:0] hdb3_select,
	// Serial host port connections
	output logic serial_data_in,
	output logic serial_chip_select,
	input wire logic serial_data_out,
	input wire logic serial_out_drive,
	// Analog control outputs
	output logic [NCH-1:0] rx_equalizer_on,
	output logic [NCH-1:0] receiver_enabled,
	output logic [NCH-1:0] monitor_active,
	output logic [NCH-1:0] signal_loss_alarm,
	// Framer side
	output logic [NCH-1:0] recovered_clock_out,
	output logic [NCH-1:0] rx_positive_data,
	output logic [NCH-1:0] rx_negative_data,
	output logic host_mode
);
	// ==========================================================
	// Pin synchronisers
	logic [RXIC_ASY_W-1:0] asy_raw;   // Asynchronous pins except the monitor and mode pins
	logic [RXIC_ASY_W-1:0] s1;        // First stage, read by s2 only
	logic [RXIC_ASY_W-1:0] s2;        // Second stage
	logic [RXIC_ASY_W-1:0] s3;        // Third stage
	logic [RXIC_ASY_W-1:0] filt;      // Agreed pin levels
	logic mon_s1;                     // Monitor pin, first stage
	logic mon_s2;                     // Monitor pin, second stage
	logic mon_s3;                     // Monitor pin, third stage
	logic mon_f;                      // Agreed monitor pin level
	logic mode_s1;                    // Mode pin, first stage
	logic mode_s2;                    // Mode pin, second stage
	logic mode_s3;                    // Mode pin, third stage

	assign asy_raw = {rx_clock_invert_pin, receiver_turn_on, rx_equalizer_enable_pin,
		los_detect, line_neg, line_pos, line_clock};

	// Three stages; a level counts once stages two and three agree
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			s1 <= RXIC_ASY_RST;
			s2 <= RXIC_ASY_RST;
			s3 <= RXIC_ASY_RST;
			filt <= RXIC_ASY_RST;
			{mon_s1, mon_s2, mon_s3, mon_f} <= 4'h0;
			{mode_s1, mode_s2, mode_s3, host_mode} <= 4'h0;
		end else begin
			s1 <= asy_raw;
			s2 <= s1;
			s3 <= s2;
			filt <= (s2 & s3) | (filt & (s2 ^ s3));
			mon_s1 <= rx_monitor_mode_pin_in;
			mon_s2 <= mon_s1;
			mon_s3 <= mon_s2;
			if (mon_s2 == mon_s3) begin
				mon_f <= mon_s3;
			end
			mode_s1 <= host_mode_pin;
			mode_s2 <= mode_s1;
			mode_s3 <= mode_s2;
			if (mode_s2 == mode_s3) begin
				host_mode <= mode_s3;
			end
		end
	end

	// Named slices of the agreed levels
	logic [NCH-1:0] lclk_f;           // Line clocks
	logic [NCH-1:0] lpos_f;           // Positive pulses
	logic [NCH-1:0] lneg_f;           // Negative pulses
	logic [NCH-1:0] los_f;            // Loss detectors
	logic [NCH-1:0] eq_f;             // Equaliser pins
	logic receiver_turn_on_f;                     // Turn-on pin
	logic cinv_f;                     // Invert pin

	assign lclk_f = filt[RXIC_P_LCLK +: NCH];
	assign lpos_f = filt[RXIC_P_LPOS +: NCH];
	assign lneg_f = filt[RXIC_P_LNEG +: NCH];
	assign los_f = filt[RXIC_P_LOS +: NCH];
	assign eq_f = filt[RXIC_P_EQ +: NCH];
	assign receiver_turn_on_f = filt[RXIC_P_RECEIVER_TURN_ON];
	assign cinv_f = filt[RXIC_P_CINV];

	// ==========================================================
	// Pin multiplexing by mode
	logic [NCH-1:0] next_inv;         // Effective clock invert per channel

	always_comb begin
		next_inv = host_mode ? rx_clock_invert_bit : {NCH{cinv_f}};
	end

	// Control outputs chosen from pins or host bits
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rx_equalizer_on <= RXIC_CH_RST;
			receiver_enabled <= RXIC_CH_RST;
			monitor_active <= RXIC_CH_RST;
			signal_loss_alarm <= RXIC_CH_RST;
			serial_data_in <= 1'b0;
			serial_chip_select <= 1'b0;
			rx_monitor_mode_pin_out <= 1'b0;
			rx_monitor_mode_pin_oe_n <= 1'b1;
		end else begin
			if (host_mode) begin
				// Pins ignored, host bits steer the channels
				rx_equalizer_on <= host_equalizer_bit;
				receiver_enabled <= host_receiver_enable;
				monitor_active <= host_monitor_bit;
			end else begin
				rx_equalizer_on <= eq_f;
				receiver_enabled <= {NCH{receiver_turn_on_f}};
				monitor_active <= {NCH{mon_f}};
			end
			// Alarm held off while monitoring
			signal_loss_alarm <= los_f & ~(host_mode ? host_monitor_bit : {NCH{mon_f}});
			// Serial port views of the shared pins
			serial_data_in <= host_mode & receiver_turn_on_f;
			serial_chip_select <= host_mode & cinv_f;
			rx_monitor_mode_pin_out <= host_mode & serial_data_out;
			rx_monitor_mode_pin_oe_n <= ~(host_mode & serial_out_drive);
		end
	end

	// ==========================================================
	// Line decoder, one lane per channel
	logic [NCH-1:0] lclk_d;           // Line clock one cycle ago
	logic [NCH-1:0] lclk_dd;          // Line clock two cycles ago, times the launch
	logic [NCH-1:0] line_pulse;       // A pulse on either rail this bit
	logic [NCH-1:0] line_bpv;         // Pulse repeats the previous polarity
	logic [NCH-1:0] subst_hit;        // Violation completes a substitution pattern
	logic [RXIC_WIN-1:0] win_p [NCH]; // Positive pulse history, newest at 0
	logic [RXIC_WIN-1:0] win_n [NCH]; // Negative pulse history
	logic [RXIC_WIN-1:0] win_v [NCH]; // Violation flags aligned to history
	logic [NCH-1:0] last_pol;         // Polarity of the last pulse
	logic [NCH-1:0] seen_pulse;       // A pulse has been seen since reset
	logic [NCH-1:0] buf_in_ready;     // Buffer can take a word
	logic [NCH-1:0] buf_out_valid;    // Buffer holds a word
	logic [NCH-1:0] pop_req;          // Launch edge drains the buffer
	logic [RXIC_WORD_W-1:0] buf_in [NCH];  // Word written
	logic [RXIC_WORD_W-1:0] buf_out [NCH]; // Word launched
	logic [NCH-1:0] push_req;         // Word offered on a line clock rise

	// Rising or falling edge on a sampled clock
	function automatic logic edge_of(input logic now, input logic was, input logic rise);
		edge_of = rise ? (now && !was) : (!now && was);
	endfunction

	// Zero bits ahead of a violation that make it a substitution
	function automatic logic is_subst(input logic hdb3, input logic [RXIC_WIN-1:0] p,
			input logic [RXIC_WIN-1:0] n);
		logic [RXIC_WIN-1:0] any;
		any = p | n;
		is_subst = hdb3 ? (any[1:0] == 2'h0) : (any[0] == 1'b0);
	endfunction

	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			push_req[c] = receiver_enabled[c] && edge_of(lclk_f[c], lclk_d[c], 1'b1);
			pop_req[c] = edge_of(lclk_d[c], lclk_dd[c], next_inv[c]);
			line_pulse[c] = lpos_f[c] | lneg_f[c];
			line_bpv[c] = line_pulse[c] && seen_pulse[c] && (lpos_f[c] == last_pol[c]);
			subst_hit[c] = single_rail[c] && decoder_enable[c] && line_bpv[c]
				&& is_subst(hdb3_select[c], win_p[c], win_n[c]);
			if (single_rail[c]) begin
				buf_in[c] = {win_p[c][RXIC_WIN-1] | win_n[c][RXIC_WIN-1],
					win_v[c][RXIC_WIN-1]};
			end else begin
				buf_in[c] = {win_p[c][RXIC_WIN-1], win_n[c][RXIC_WIN-1]};
			end
		end
	end

	// History shift on each accepted rise, substitutions zeroed in place
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			lclk_d <= RXIC_CH_RST;
			lclk_dd <= RXIC_CH_RST;
			last_pol <= RXIC_CH_RST;
			seen_pulse <= RXIC_CH_RST;
			for (int c = 0; c < NCH; c++) begin
				win_p[c] <= RXIC_WIN_RST;
				win_n[c] <= RXIC_WIN_RST;
				win_v[c] <= RXIC_WIN_RST;
			end
		end else begin
			lclk_d <= lclk_f;
			lclk_dd <= lclk_d;
			for (int c = 0; c < NCH; c++) begin
				if (push_req[c] && buf_in_ready[c]) begin
					if (subst_hit[c]) begin
						// Pattern zeroed; B3ZS keeps the data bit ahead of B
						win_p[c] <= {win_p[c][RXIC_WIN-2] & ~hdb3_select[c], 3'h0};
						win_n[c] <= {win_n[c][RXIC_WIN-2] & ~hdb3_select[c], 3'h0};
						win_v[c] <= {win_v[c][RXIC_WIN-2:0], 1'b0};
					end else begin
						win_p[c] <= {win_p[c][RXIC_WIN-2:0], lpos_f[c]};
						win_n[c] <= {win_n[c][RXIC_WIN-2:0], lneg_f[c] & ~lpos_f[c]};
						win_v[c] <= {win_v[c][RXIC_WIN-2:0], line_bpv[c]};
					end
					if (line_pulse[c]) begin
						last_pol[c] <= lpos_f[c];
						seen_pulse[c] <= 1'b1;
					end
				end
			end
		end
	end

	// ==========================================================
	// Output buffers, one per channel
	for (genvar g = 0; g < NCH; g++) begin : g_buf
		rxic_buf #(
			.W(RXIC_WORD_W),
			.DEPTH(RXIC_BUF_DEPTH)
		) u_buf (
			.ref_clk(ref_clk),
			.sys_rst(sys_rst),
			.in_valid(push_req[g]),
			.in_ready(buf_in_ready[g]),
			.in_data(buf_in[g]),
			.out_valid(buf_out_valid[g]),
			.out_ready(pop_req[g]),
			.out_data(buf_out[g])
		);
	end

	// Launch rails one cycle after the output clock's falling edge
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			recovered_clock_out <= RXIC_CH_RST;
			rx_positive_data <= RXIC_CH_RST;
			rx_negative_data <= RXIC_CH_RST;
		end else begin
			recovered_clock_out <= lclk_f ^ next_inv;
			for (int c = 0; c < NCH; c++) begin
				if (!receiver_enabled[c]) begin
					// Receiver off, rails quiet
					rx_positive_data[c] <= 1'b0;
					rx_negative_data[c] <= 1'b0;
				end else if (pop_req[c] && buf_out_valid[c]) begin
					rx_positive_data[c] <= buf_out[c][1];
					rx_negative_data[c] <= buf_out[c][0];
				end
			end
		end
	end

	// ==========================================================
	// Checks
	sequence s_host_steady;
		host_mode && $stable(host_mode);
	endsequence

	sequence s_hw_steady;
		!host_mode && $stable(host_mode);
	endsequence

	a_eq_hw_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_hw_steady |=> rx_equalizer_on == $past(eq_f)) else $error("equaliser not following pin");
	a_eq_host_ignore: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_host_steady |=> rx_equalizer_on == $past(host_equalizer_bit))
		else $error("equaliser pin not ignored");
	a_rx_turn_on: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_hw_steady ##0 receiver_turn_on_f |=> &receiver_enabled) else $error("receivers not enabled");
	a_sdi_route: assert property (@(posedge ref_clk) disable iff (sys_rst)
		serial_data_in |-> $past(host_mode) && $past(receiver_turn_on_f)) else $error("serial data in misrouted");
	a_mon_hw: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_hw_steady ##0 mon_f |=> &monitor_active) else $error("monitor pin not applied");
	a_los_block: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_hw_steady ##0 mon_f |=> signal_loss_alarm == '0) else $error("alarm raised while monitoring");
	a_mon_host: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_host_steady |=> monitor_active == $past(host_monitor_bit)) else $error("host monitor bits lost");
	a_sdo_drive: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!rx_monitor_mode_pin_oe_n |-> $past(host_mode) && $past(serial_out_drive))
		else $error("monitor pin driven outside host mode");
	a_clk_invert: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_hw_steady ##0 cinv_f |=> recovered_clock_out == ~$past(lclk_f))
		else $error("recovered clock not inverted");
	a_cs_route: assert property (@(posedge ref_clk) disable iff (sys_rst)
		serial_chip_select |-> $past(host_mode) && $past(cinv_f)) else $error("chip select misrouted");
	for (genvar g = 0; g < NCH; g++) begin : g_launch
		a_launch_edge: assert property (@(posedge ref_clk) disable iff (sys_rst)
			$changed({rx_positive_data[g], rx_negative_data[g]}) && $past(receiver_enabled[g])
				|-> $past(recovered_clock_out[g], 2) && !$past(recovered_clock_out[g]))
			else $error("data launched off the falling edge");
	end
endmodule

/* hw/rxic_pkg.sv */
/*
 * Constants shared by the receive interface control block and its buffer.
 * Assumes a 200 MHz ref_clk that samples every pin and the recovered line clocks.
 */
package rxic_pkg;
	// ==========================================================
	// Geometry
	localparam int RXIC_NCH = 2;          // Channels served
	localparam int RXIC_WIN = 4;          // Decoder look-back window in bits
	localparam int RXIC_BUF_DEPTH = 2;    // Entries in the output buffer
	localparam int RXIC_WORD_W = 2;       // Positive rail plus negative/violation rail

	// ==========================================================
	// Bit positions inside the synchronised pin vector
	localparam int RXIC_ASY_W = 12;       // Width of the pin vector
	localparam int RXIC_P_LCLK = 0;       // Recovered line clocks, two bits
	localparam int RXIC_P_LPOS = 2;       // Positive line pulses, two bits
	localparam int RXIC_P_LNEG = 4;       // Negative line pulses, two bits
	localparam int RXIC_P_LOS = 6;        // Raw loss detector outputs, two bits
	localparam int RXIC_P_EQ = 8;         // Equaliser enable pins, two bits
	localparam int RXIC_P_RECEIVER_TURN_ON = 10;      // Receiver turn-on / serial data in
	localparam int RXIC_P_CINV = 11;      // Clock invert / chip select

	// ==========================================================
	// Reset values
	localparam logic [RXIC_ASY_W-1:0] RXIC_ASY_RST = 12'h000;
	localparam logic [RXIC_WIN-1:0] RXIC_WIN_RST = 4'h0;
	localparam logic [RXIC_NCH-1:0] RXIC_CH_RST = 2'h0;
endpackage

/* hw/rxic_buf.sv */
/*
 * Small FIFO with valid/ready on both sides, depth and width as parameters.
 * Assumes a single clock domain and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module rxic_buf import rxic_pkg::*; #(
	parameter int W = RXIC_WORD_W,
	parameter int DEPTH = RXIC_BUF_DEPTH
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// ==========================================================
	// Storage
	logic [W-1:0] mem [DEPTH];        // Entries
	logic [AW-1:0] wr_ptr;            // Next slot written
	logic [AW-1:0] rd_ptr;            // Oldest slot
	logic [AW:0] count;               // Entries held
	logic push;                       // Word accepted
	logic pop;                        // Word taken

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];

	// Pointer wrap
	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction

	// Write port
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Pointers and occupancy
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= bump(wr_ptr);
			end
			if (pop) begin
				rd_ptr <= bump(rd_ptr);
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

/* test/rxic_framer.sv */
/*
 * Behavioural framer for one channel: captures the rail pair on the chosen
 * edge of the recovered clock and keeps every captured word in a queue.
 * Assumes the bench reads the queue by hierarchy and clears it between streams.
 */
`timescale 1ns/1ps
module rxic_framer (
	// Recovered clock and rails
	input wire logic rclk,
	input wire logic pos,
	input wire logic neg,
	// Capture edge select and queue clear
	input wire logic fall_edge,
	input wire logic clear
);
	// ==========================================================
	// Capture
	logic [1:0] cap[$]; // Captured {pos, neg} words, oldest first

	// Default capture on the rising recovered clock
	always @(posedge rclk) begin
		if (!fall_edge) cap.push_back({pos, neg});
	end

	// Inverted clock: capture on the falling edge
	always @(negedge rclk) begin
		if (fall_edge) cap.push_back({pos, neg});
	end

	// Drop old words before a new stream
	always @(posedge clear) begin
		cap.delete();
	end
endmodule

/* test/rxic_top_tb.sv */
/*
 * Self-checking bench for the receive interface control block: pin mapping
 * in both modes and rail streams seen by two framer models.
 * Assumes the package and design files of hw/ are compiled first.
 */
`timescale 1ns/1ps
module rxic_top_tb;
	// ==========================================================
	// Stimulus and observed signals
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic host_mode_pin = 1'b0;
	logic receiver_turn_on = 1'b0;
	logic rx_clock_invert_pin = 1'b0;
	logic serial_data_out = 1'b0;
	logic serial_out_drive = 1'b0;
	logic mon_drv = 1'b0; // Bench drive of the two-way monitor pin
	logic lclk; // Shared line clock for both channels
	logic lc_en = 1'b0; // Line clock runs only during a stream
	logic clr = 1'b0;
	logic [1:0] cap_fall = 2'h0; // Framer capture edge per channel
	logic [1:0] rx_equalizer_enable_pin = 2'h0;
	logic [1:0] line_pos = 2'h0;
	logic [1:0] line_neg = 2'h0;
	logic [1:0] los_detect = 2'h0;
	logic [1:0] host_equalizer_bit = 2'h0;
	logic [1:0] host_receiver_enable = 2'h0;
	logic [1:0] host_monitor_bit = 2'h0;
	logic [1:0] rx_clock_invert_bit = 2'h0;
	logic [1:0] single_rail = 2'h0;
	logic [1:0] decoder_enable = 2'h0;
	logic [1:0] hdb3_select = 2'h0;
	logic [1:0] line_clock;
	logic rx_monitor_mode_pin_in;
	logic rx_monitor_mode_pin_out, rx_monitor_mode_pin_oe_n, serial_data_in;
	logic serial_chip_select, host_mode;
	logic [1:0] rx_equalizer_on, receiver_enabled, monitor_active, signal_loss_alarm;
	logic [1:0] recovered_clock_out, rx_positive_data, rx_negative_data;
	int n_fail = 0;
	int samples_checked = 0;
	int cyc = 0;

	// Pin level: the block wins while its enable is low
	assign rx_monitor_mode_pin_in = rx_monitor_mode_pin_oe_n ? mon_drv : rx_monitor_mode_pin_out;
	assign line_clock = {2{lclk}};

	// ==========================================================
	// Clocks
	always #2.5 ref_clk = ~ref_clk;

	// 64 ns line clock, offset so its edges never meet ref_clk edges
	initial begin
		lclk = 1'b0;
		#0.7;
		forever begin
			#32;
			lclk = lc_en ? ~lclk : 1'b0;
		end
	end

	// ==========================================================
	// Design and framers
	rxic_top dut (.ref_clk, .sys_rst, .host_mode_pin, .rx_equalizer_enable_pin,
		.receiver_turn_on, .rx_clock_invert_pin, .rx_monitor_mode_pin_in,
		.rx_monitor_mode_pin_out, .rx_monitor_mode_pin_oe_n, .line_clock, .line_pos,
		.line_neg, .los_detect, .host_equalizer_bit, .host_receiver_enable,
		.host_monitor_bit, .rx_clock_invert_bit, .single_rail, .decoder_enable,
		.hdb3_select, .serial_data_in, .serial_chip_select, .serial_data_out,
		.serial_out_drive, .rx_equalizer_on, .receiver_enabled, .monitor_active,
		.signal_loss_alarm, .recovered_clock_out, .rx_positive_data,
		.rx_negative_data, .host_mode);
	rxic_framer fr0 (.rclk(recovered_clock_out[0]), .pos(rx_positive_data[0]),
		.neg(rx_negative_data[0]), .fall_edge(cap_fall[0]), .clear(clr));
	rxic_framer fr1 (.rclk(recovered_clock_out[1]), .pos(rx_positive_data[1]),
		.neg(rx_negative_data[1]), .fall_edge(cap_fall[1]), .clear(clr));

	// ==========================================================
	// Helpers
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// One line symbol, changed at the falling line clock
	task automatic send_sym(input byte c);
		@(negedge lclk);
		line_pos <= {2{c == "+"}};
		line_neg <= {2{c == "-"}};
	endtask

	// Contiguous search of the expected words in a capture
	function automatic logic found(input logic [1:0] got[$], input logic [1:0] want[$]);
		logic ok;
		for (int i = 0; i + want.size() <= got.size(); i++) begin
			ok = 1'b1;
			for (int j = 0; j < want.size(); j++)
				if (got[i + j] !== want[j]) ok = 1'b0;
			if (ok) return 1'b1;
		end
		return 1'b0;
	endfunction

	// Send a framed symbol string and look for the expected rail words
	task automatic run_stream(input string tx, input string ep, input string en,
		input string msg);
		logic [1:0] want[$];
		for (int i = 0; i < ep.len(); i++) want.push_back({ep[i] == "1", en[i] == "1"});
		clr <= 1'b1;
		wait_cyc(2);
		clr <= 1'b0;
		lc_en = 1'b1;
		repeat (8) send_sym("0");
		for (int i = 0; i < tx.len(); i++) send_sym(tx[i]);
		repeat (12) send_sym("0");
		lc_en = 1'b0;
		wait_cyc(40);
		check(8'(found(fr0.cap, want)), 8'h01, {msg, " ch0"});
		check(8'(found(fr1.cap, want)), 8'h01, {msg, " ch1"});
		$display("test %s done", msg);
	endtask

	// ==========================================================
	// Timeout
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			stop_test();
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		wait_cyc(20);
		sys_rst <= 1'b0;
		wait_cyc(2);
		check(rx_monitor_mode_pin_oe_n, 8'h01, "oe after reset");
		check(host_mode, 8'h00, "mode after reset");
		// Hardware mode pin mapping
		for (int v = 0; v < 4; v++) begin
			rx_equalizer_enable_pin <= 2'(v);
			wait_cyc(8);
			check(rx_equalizer_on, 8'(v), "equaliser");
		end
		receiver_turn_on <= 1'b1;
		los_detect <= 2'h3;
		mon_drv <= 1'b1;
		wait_cyc(8);
		check(receiver_enabled, 8'h03, "receivers on");
		check(monitor_active, 8'h03, "monitor hw");
		check(signal_loss_alarm, 8'h00, "alarm held");
		check(serial_data_in, 8'h00, "sdi hw");
		check(rx_monitor_mode_pin_oe_n, 8'h01, "pin released hw");
		mon_drv <= 1'b0;
		rx_clock_invert_pin <= 1'b1;
		wait_cyc(8);
		check(signal_loss_alarm, 8'h03, "alarm free");
		check(recovered_clock_out, 8'h03, "clock inverted");
		check(serial_chip_select, 8'h00, "cs hw");
		$display("test hardware pins done");
		// Streams, hardware mode
		cap_fall <= 2'h3;
		run_stream("+0-0+-", "100010", "001001", "dual inverted");
		rx_clock_invert_pin <= 1'b0;
		cap_fall <= 2'h0;
		wait_cyc(8);
		run_stream("+0-0+-", "100010", "001001", "dual");
		single_rail <= 2'h3;
		run_stream("+-++-", "11111", "00010", "violation");
		decoder_enable <= 2'h3;
		hdb3_select <= 2'h3;
		run_stream("+000+-00-+-", "10000000011", "00000000000", "hdb3");
		hdb3_select <= 2'h0;
		run_stream("+-+0+-00+-", "1100010011", "0000000000", "b3zs");
		// Host mode pin mapping
		single_rail <= 2'h0;
		host_mode_pin <= 1'b1;
		host_equalizer_bit <= 2'h1;
		host_receiver_enable <= 2'h2;
		host_monitor_bit <= 2'h1;
		rx_clock_invert_bit <= 2'h2;
		rx_equalizer_enable_pin <= 2'h3;
		mon_drv <= 1'b1;
		rx_clock_invert_pin <= 1'b1;
		serial_out_drive <= 1'b1;
		serial_data_out <= 1'b1;
		wait_cyc(8);
		check(host_mode, 8'h01, "host mode");
		check(rx_equalizer_on, 8'h01, "eq pins ignored");
		check(receiver_enabled, 8'h02, "host enables");
		check(monitor_active, 8'h01, "host monitor");
		check(signal_loss_alarm, 8'h02, "host alarm");
		check(serial_data_in, 8'h01, "sdi host");
		check(serial_chip_select, 8'h01, "cs host");
		check(rx_monitor_mode_pin_oe_n, 8'h00, "pin driven");
		check(rx_monitor_mode_pin_out, 8'h01, "sdo high");
		check(recovered_clock_out, 8'h02, "host invert bit");
		serial_data_out <= 1'b0;
		receiver_turn_on <= 1'b0;
		wait_cyc(8);
		check(rx_monitor_mode_pin_out, 8'h00, "sdo low");
		check(serial_data_in, 8'h00, "sdi low");
		$display("test host pins done");
		// Per-channel capture edge in host mode
		host_receiver_enable <= 2'h3;
		cap_fall <= 2'h2;
		wait_cyc(8);
		run_stream("+0-0+-", "100010", "001001", "host mixed edges");
		stop_test();
	end
endmodule
